// ===== common/cir_cfg.svh
// addresses, indexes, field positions and reset values of the indexed
// controller register bridge; assumes an 8-bit register bus with pages
`ifndef CIR_CFG_SVH
`define CIR_CFG_SVH

`define CIR_PAGE_CAN 8'h01
`define CIR_SFR_CONTROL 8'hF8
`define CIR_SFR_TEST 8'hDB
`define CIR_SFR_STATUS 8'hC0
`define CIR_SFR_DATA_LOW 8'hD8
`define CIR_SFR_DATA_HIGH 8'hD9
`define CIR_SFR_INDEX 8'hDA

`define CIR_IDX_CONTROL 7'h00
`define CIR_IDX_STATUS 7'h01
`define CIR_IDX_ERROR 7'h02
`define CIR_IDX_BIT_TIMING 7'h03
`define CIR_IDX_INTERRUPT 7'h04
`define CIR_IDX_TEST 7'h05
`define CIR_IDX_PRESCALE_EXT 7'h06
`define CIR_IDX_SET1_BASE 7'h08
`define CIR_IDX_SET1_LAST 7'h12
`define CIR_IDX_SET2_BASE 7'h20
`define CIR_IDX_SET2_LAST 7'h2A
`define CIR_IDX_TXREQ 7'h40
`define CIR_IDX_NEWDATA 7'h48
`define CIR_IDX_INTPEND 7'h50
`define CIR_IDX_VALID 7'h58

`define CIR_OFF_CMD_REQ 4'h0
`define CIR_OFF_CMD_MASK 4'h1
`define CIR_OFF_FIRST_STORED 4'h2
`define CIR_OFF_MASK1 4'h2
`define CIR_OFF_MASK2 4'h3
`define CIR_OFF_ARB1 4'h4
`define CIR_OFF_ARB2 4'h5
`define CIR_OFF_MSG_CTL 4'h6
`define CIR_SET_WORDS 11
`define CIR_OBJ_WORDS 9
`define CIR_OBJECTS 32
`define CIR_INDEX_WORDS 128

`define CIR_RST_CONTROL 16'h0001
`define CIR_RST_BIT_TIMING 16'h2301
`define CIR_RST_CMD_REQ 16'h0001
`define CIR_RST_MASK 16'hFFFF
`define CIR_RST_ZERO 16'h0000

`define CIR_CTL_TEST_BIT 7
`define CIR_CTL_CCE_BIT 6
`define CIR_TEST_RX_BIT 7
`define CIR_STAT_RXOK_BIT 4
`define CIR_CMDREQ_BUSY_BIT 15
`define CIR_CMDMASK_WR_BIT 7
`define CIR_ARB2_VALID_BIT 15
`define CIR_ARB2_XTD_BIT 14
`define CIR_ARB2_DIR_BIT 13
`define CIR_MCTL_NEWDAT_BIT 15
`define CIR_MCTL_INTPND_BIT 13
`define CIR_MCTL_RXIE_BIT 10
`define CIR_MCTL_TXRQ_BIT 8
`define CIR_STD_ID_SHIFT 18
`define CIR_PRESCALE_W 10

`define CIR_CLOCK_HZ 40000000
`define CIR_MAX_BIT_RATE 1000000
`define CIR_MIN_BIT_CYCLES (`CIR_CLOCK_HZ / `CIR_MAX_BIT_RATE)

`endif

// ===== common/cir_pkg.sv
// types shared by the indexed controller register bridge
package cir_pkg;
   typedef logic [15:0] cir_word_t;
   typedef logic [6:0] cir_index_t;
   typedef enum logic [0:0] {
      CIR_XFER_IDLE = 1'b0,
      CIR_XFER_RUN = 1'b1
   } cir_xfer_state_t;
endpackage

// ===== core/cir_can_index_bridge.sv
// indexed access bridge from the 8-bit register bus into the controller
// register space, message memory and acceptance filter
// assumes a single-cycle register bus on mclk; frame events come from a
// protocol engine on the same clock
// Contract
// - index space of 128 sixteen-bit words
// - pointer selects target of data byte accesses
// - low byte register low half, high byte high
// - index 0x03 selects bit timing
// - low data byte register is bit addressable
// - control, test, status also directly mapped
// - all other registers only through index
// - command request write moves interface set
// - 32 message objects held in memory
// - message handler registers read only, indexed
// - controller runs on the core clock
// - bit rates up to 1 Mbit/s
// - controller itself does acceptance filtering
// - message memory separate from host memory
// - standard and extended identifiers both supported
// - pointer advances on data low in set ranges
`timescale 1ns/1ps
`include "cir_cfg.svh"
`default_nettype none

module cir_can_index_bridge
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_page,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic sfr_bit_wr,
   input wire logic [2:0] sfr_bit_sel,
   input wire logic sfr_bit_val,
   input wire logic can_rx,
   input wire logic rx_frame_stb,
   input wire logic [28:0] rx_frame_id,
   input wire logic rx_frame_xtd,
   output var logic [7:0] sfr_rdata,
   output var logic can_tx,
   output var logic quantum_tick
);

   function automatic logic in_autoinc(input cir_pkg::cir_index_t idx);
      in_autoinc = (idx >= `CIR_IDX_SET1_BASE && idx <= `CIR_IDX_SET1_LAST) ||
                   (idx >= `CIR_IDX_SET2_BASE && idx <= `CIR_IDX_SET2_LAST);
   endfunction

   function automatic logic id_match(input logic [28:0] id, input logic xtd,
                                     input cir_pkg::cir_word_t a1, input cir_pkg::cir_word_t a2,
                                     input cir_pkg::cir_word_t m1, input cir_pkg::cir_word_t m2);
      logic [28:0] oid;
      logic [28:0] msk;
      begin
         oid = {a2[12:0], a1};
         msk = {m2[12:0], m1};
         if (xtd)
         begin
            id_match = ((oid ^ id) & msk) == 29'h0000000;
         end
         else
         begin
            id_match = (((oid ^ id) & msk) >> `CIR_STD_ID_SHIFT) == 29'h0000000;
         end
      end
   endfunction

   cir_pkg::cir_word_t ctl_mem [0:`CIR_INDEX_WORDS-1];
   cir_pkg::cir_word_t obj_mem [0:`CIR_OBJECTS-1][0:`CIR_OBJ_WORDS-1];

   logic [6:0] index_q;
   logic [6:0] index_d;
   logic [7:0] stage_high_q;
   logic [1:0] rx_sync_q;
   logic xfer_set_q;
   logic [4:0] xfer_obj_q;
   logic xfer_go_q;
   cir_pkg::cir_xfer_state_t xfer_state_q;
   cir_pkg::cir_xfer_state_t xfer_state_d;
   logic [`CIR_PRESCALE_W-1:0] tq_count_q;

   logic [31:0] flag_valid;
   logic [31:0] flag_txrq;
   logic [31:0] flag_newdat;
   logic [31:0] flag_intpnd;
   logic [31:0] rx_hit;
   logic [4:0] rx_obj;
   logic rx_any;

   wire page_ok = sfr_page == `CIR_PAGE_CAN;
   wire low_sel = page_ok && sfr_addr == `CIR_SFR_DATA_LOW;
   wire high_sel = page_ok && sfr_addr == `CIR_SFR_DATA_HIGH;
   wire index_sel = page_ok && sfr_addr == `CIR_SFR_INDEX;
   wire ctrl_sel = page_ok && sfr_addr == `CIR_SFR_CONTROL;
   wire test_sel = page_ok && sfr_addr == `CIR_SFR_TEST;
   wire stat_sel = page_ok && sfr_addr == `CIR_SFR_STATUS;

   wire cir_pkg::cir_word_t sel_word;
   wire cir_pkg::cir_word_t ctrl_word = ctl_mem[`CIR_IDX_CONTROL];
   wire cir_pkg::cir_word_t test_word = ctl_mem[`CIR_IDX_TEST];
   wire cir_pkg::cir_word_t stat_word = ctl_mem[`CIR_IDX_STATUS];

   // bit write merges one bit into the low byte
   wire [7:0] bit_merged = (sel_word[7:0] & ~(8'h01 << sfr_bit_sel)) |
                           ({7'h00, sfr_bit_val} << sfr_bit_sel);
   wire low_write = (sfr_wr && low_sel) || (sfr_bit_wr && low_sel);
   wire [7:0] low_value = sfr_bit_wr ? bit_merged : sfr_wdata;
   // staged high byte joins the low byte
   wire cir_pkg::cir_word_t commit_word = {stage_high_q, low_value};

   // bit timing only while configuration enabled
   wire allow_bt = ctrl_word[`CIR_CTL_CCE_BIT];
   wire allow_test = ctrl_word[`CIR_CTL_TEST_BIT];

   wire [6:0] set1_off = index_q - `CIR_IDX_SET1_BASE;
   wire [6:0] set2_off = index_q - `CIR_IDX_SET2_BASE;
   wire in_set1 = index_q >= `CIR_IDX_SET1_BASE && index_q <= `CIR_IDX_SET1_LAST;
   wire in_set2 = index_q >= `CIR_IDX_SET2_BASE && index_q <= `CIR_IDX_SET2_LAST;
   wire cmd_req_hit = (in_set1 && set1_off[3:0] == `CIR_OFF_CMD_REQ) ||
                      (in_set2 && set2_off[3:0] == `CIR_OFF_CMD_REQ);

   // only these indexes take indexed writes
   wire idx_writable = index_q == `CIR_IDX_CONTROL || index_q == `CIR_IDX_STATUS ||
                       (index_q == `CIR_IDX_BIT_TIMING && allow_bt) ||
                       (index_q == `CIR_IDX_TEST && allow_test) ||
                       (index_q == `CIR_IDX_PRESCALE_EXT && allow_test) ||
                       in_set1 || in_set2;

   // message handler flags gathered from the objects
   always_comb
   begin
      rx_hit = 32'h00000000;
      for (int i = 0; i < `CIR_OBJECTS; i++)
      begin
         flag_valid[i] = obj_mem[i][`CIR_OFF_ARB2 - `CIR_OFF_FIRST_STORED][`CIR_ARB2_VALID_BIT];
         flag_txrq[i] = obj_mem[i][`CIR_OFF_MSG_CTL - `CIR_OFF_FIRST_STORED][`CIR_MCTL_TXRQ_BIT];
         flag_newdat[i] = obj_mem[i][`CIR_OFF_MSG_CTL - `CIR_OFF_FIRST_STORED][`CIR_MCTL_NEWDAT_BIT];
         flag_intpnd[i] = obj_mem[i][`CIR_OFF_MSG_CTL - `CIR_OFF_FIRST_STORED][`CIR_MCTL_INTPND_BIT];
         // filtering done here, not by host
         rx_hit[i] = flag_valid[i] &&
                     !obj_mem[i][`CIR_OFF_ARB2 - `CIR_OFF_FIRST_STORED][`CIR_ARB2_DIR_BIT] &&
                     obj_mem[i][`CIR_OFF_ARB2 - `CIR_OFF_FIRST_STORED][`CIR_ARB2_XTD_BIT] ==
                     rx_frame_xtd &&
                     id_match(rx_frame_id, rx_frame_xtd,
                              obj_mem[i][`CIR_OFF_ARB1 - `CIR_OFF_FIRST_STORED],
                              obj_mem[i][`CIR_OFF_ARB2 - `CIR_OFF_FIRST_STORED],
                              obj_mem[i][`CIR_OFF_MASK1 - `CIR_OFF_FIRST_STORED],
                              obj_mem[i][`CIR_OFF_MASK2 - `CIR_OFF_FIRST_STORED]);
      end
      rx_obj = 5'h00;
      rx_any = 1'b0;
      for (int i = `CIR_OBJECTS - 1; i >= 0; i--)
      begin
         if (rx_hit[i])
         begin
            rx_obj = 5'(i);
            rx_any = 1'b1;
         end
      end
   end

   // pointer chooses the word seen by data bytes
   assign sel_word =
      (index_q == `CIR_IDX_TXREQ) ? flag_txrq[15:0] :
      (index_q == `CIR_IDX_TXREQ + 7'h01) ? flag_txrq[31:16] :
      (index_q == `CIR_IDX_NEWDATA) ? flag_newdat[15:0] :
      (index_q == `CIR_IDX_NEWDATA + 7'h01) ? flag_newdat[31:16] :
      (index_q == `CIR_IDX_INTPEND) ? flag_intpnd[15:0] :
      (index_q == `CIR_IDX_INTPEND + 7'h01) ? flag_intpnd[31:16] :
      (index_q == `CIR_IDX_VALID) ? flag_valid[15:0] :
      (index_q == `CIR_IDX_VALID + 7'h01) ? flag_valid[31:16] :
      (index_q == `CIR_IDX_TEST) ?
         {test_word[15:8], rx_sync_q[1], test_word[6:0]} :
      ctl_mem[index_q];

   // advance inside the interface set ranges
   always_comb
   begin
      index_d = index_q;
      if (sfr_wr && index_sel)
      begin
         index_d = sfr_wdata[6:0];
      end
      else if ((low_write || (sfr_rd && low_sel)) && in_autoinc(index_q))
      begin
         index_d = index_q + 7'h01;
      end
   end

   always_comb
   begin
      xfer_state_d = cir_pkg::CIR_XFER_IDLE;
      case (xfer_state_q)
         cir_pkg::CIR_XFER_IDLE:
         begin
            if (xfer_go_q)
            begin
               xfer_state_d = cir_pkg::CIR_XFER_RUN;
            end
         end
         default:
         begin
            xfer_state_d = cir_pkg::CIR_XFER_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         index_q <= 7'h00;
         stage_high_q <= 8'h00;
         rx_sync_q <= 2'b11;
         xfer_state_q <= cir_pkg::CIR_XFER_IDLE;
         sfr_rdata <= 8'h00;
         can_tx <= 1'b1;
      end
      else
      begin
         index_q <= index_d;
         xfer_state_q <= xfer_state_d;
         rx_sync_q <= {rx_sync_q[0], can_rx};
         // recessive logic level for the transceiver
         can_tx <= 1'b1;
         if (sfr_wr && high_sel)
         begin
            stage_high_q <= sfr_wdata;
         end
         // byte lanes of the selected word
         // direct addresses read the low halves
         if (sfr_rd)
         begin
            if (low_sel)
            begin
               sfr_rdata <= sel_word[7:0];
            end
            else if (high_sel)
            begin
               sfr_rdata <= sel_word[15:8];
            end
            else if (index_sel)
            begin
               sfr_rdata <= {1'b0, index_q};
            end
            else if (ctrl_sel)
            begin
               sfr_rdata <= ctrl_word[7:0];
            end
            else if (test_sel)
            begin
               sfr_rdata <= {rx_sync_q[1], test_word[6:0]};
            end
            else if (stat_sel)
            begin
               sfr_rdata <= stat_word[7:0];
            end
            else
            begin
               sfr_rdata <= 8'h00;
            end
         end
      end
   end

   // divider reaches down to 1 Mbit/s bit times
   wire [`CIR_PRESCALE_W-1:0] brp_value =
      {ctl_mem[`CIR_IDX_PRESCALE_EXT][3:0], ctl_mem[`CIR_IDX_BIT_TIMING][5:0]};

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         tq_count_q <= '0;
         quantum_tick <= 1'b0;
      end
      else
      begin
         quantum_tick <= tq_count_q == brp_value;
         tq_count_q <= (tq_count_q == brp_value) ? '0 : tq_count_q + 1'b1;
      end
   end

   // capture a command request on commit
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         xfer_go_q <= 1'b0;
         xfer_set_q <= 1'b0;
         xfer_obj_q <= 5'h00;
      end
      else
      begin
         // valid object numbers are 1 to 32
         xfer_go_q <= low_write && cmd_req_hit && low_value[5:0] != 6'h00 &&
                      low_value[5:0] <= 6'(`CIR_OBJECTS);
         if (low_write && cmd_req_hit)
         begin
            xfer_set_q <= in_set2;
            xfer_obj_q <= 5'(low_value[5:0] - 6'h01);
         end
      end
   end

   wire [6:0] xfer_base = xfer_set_q ? `CIR_IDX_SET2_BASE : `CIR_IDX_SET1_BASE;
   wire xfer_to_obj = ctl_mem[xfer_base + 7'(`CIR_OFF_CMD_MASK)][`CIR_CMDMASK_WR_BIT];

   // words of the controller space and the message memory
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < `CIR_INDEX_WORDS; i++)
         begin
            ctl_mem[i] <= `CIR_RST_ZERO;
         end
         ctl_mem[`CIR_IDX_CONTROL] <= `CIR_RST_CONTROL;
         ctl_mem[`CIR_IDX_BIT_TIMING] <= `CIR_RST_BIT_TIMING;
         for (int s = 0; s < 2; s++)
         begin
            ctl_mem[(s == 0 ? `CIR_IDX_SET1_BASE : `CIR_IDX_SET2_BASE)] <= `CIR_RST_CMD_REQ;
            ctl_mem[(s == 0 ? `CIR_IDX_SET1_BASE : `CIR_IDX_SET2_BASE) + 7'(`CIR_OFF_MASK1)]
               <= `CIR_RST_MASK;
            ctl_mem[(s == 0 ? `CIR_IDX_SET1_BASE : `CIR_IDX_SET2_BASE) + 7'(`CIR_OFF_MASK2)]
               <= `CIR_RST_MASK;
         end
         for (int o = 0; o < `CIR_OBJECTS; o++)
         begin
            for (int w = 0; w < `CIR_OBJ_WORDS; w++)
            begin
               obj_mem[o][w] <= `CIR_RST_ZERO;
            end
         end
      end
      else
      begin
         if (xfer_go_q)
         begin
            ctl_mem[xfer_base][`CIR_CMDREQ_BUSY_BIT] <= 1'b1;
         end
         if (xfer_state_q == cir_pkg::CIR_XFER_RUN)
         begin
            ctl_mem[xfer_base][`CIR_CMDREQ_BUSY_BIT] <= 1'b0;
            for (int w = 0; w < `CIR_OBJ_WORDS; w++)
            begin
               if (xfer_to_obj)
               begin
                  obj_mem[xfer_obj_q][w] <= ctl_mem[xfer_base + 7'(`CIR_OFF_FIRST_STORED) + 7'(w)];
               end
               else
               begin
                  ctl_mem[xfer_base + 7'(`CIR_OFF_FIRST_STORED) + 7'(w)] <= obj_mem[xfer_obj_q][w];
               end
            end
         end
         if (rx_frame_stb && rx_any)
         begin
            obj_mem[rx_obj][`CIR_OFF_MSG_CTL - `CIR_OFF_FIRST_STORED][`CIR_MCTL_NEWDAT_BIT] <= 1'b1;
            if (obj_mem[rx_obj][`CIR_OFF_MSG_CTL - `CIR_OFF_FIRST_STORED][`CIR_MCTL_RXIE_BIT])
            begin
               obj_mem[rx_obj][`CIR_OFF_MSG_CTL - `CIR_OFF_FIRST_STORED][`CIR_MCTL_INTPND_BIT]
                  <= 1'b1;
            end
         end
         // direct writes reach the low halves
         if (sfr_wr && ctrl_sel)
         begin
            ctl_mem[`CIR_IDX_CONTROL][7:0] <= sfr_wdata;
         end
         if (sfr_wr && test_sel && allow_test)
         begin
            ctl_mem[`CIR_IDX_TEST][7:0] <= sfr_wdata;
         end
         if (sfr_wr && stat_sel)
         begin
            ctl_mem[`CIR_IDX_STATUS][7:0] <= sfr_wdata;
         end
         // indexed commit lands on the selected word
         if (low_write && idx_writable)
         begin
            ctl_mem[index_q] <= commit_word;
         end
         // status receive flag: set beats a clear in the same cycle
         if (rx_frame_stb && rx_any)
         begin
            ctl_mem[`CIR_IDX_STATUS][`CIR_STAT_RXOK_BIT] <= 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// ===== verif/cir_can_transceiver.sv
// bus transceiver model at the far side of the controller pins
// assumes a wired-and bus with a recessive pull-up; the bench may force it dominant
`timescale 1ns/1ps
`default_nettype none

module cir_can_transceiver
(
   input wire logic can_tx,
   input wire logic force_dom,
   output var logic can_rx
);
   assign can_rx = can_tx & ~force_dom;
endmodule

`default_nettype wire

// ===== verif/cir_can_index_bridge_props.sv
// port checker for the indexed register bridge
// assumes page 0x01 decoding and the register read latency of one edge
`timescale 1ns/1ps
`default_nettype none

module cir_can_index_bridge_props
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_page,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic can_rx,
   input wire logic [7:0] sfr_rdata,
   input wire logic can_tx
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   wire logic pg = sfr_page == 8'h01;
   wire logic rd_ptr = sfr_rd && pg && sfr_addr == 8'hDA;
   wire logic wr_ptr = sfr_wr && pg && sfr_addr == 8'hDA;
   wire logic rd_low = sfr_rd && pg && sfr_addr == 8'hD8;
   wire logic mapped = sfr_addr inside {8'hF8, 8'hDB, 8'hC0, 8'hD8, 8'hD9, 8'hDA};
   wire logic in_rng = (sfr_wdata[6:0] >= 7'h08 && sfr_wdata[6:0] <= 7'h12) ||
      (sfr_wdata[6:0] >= 7'h20 && sfr_wdata[6:0] <= 7'h2A);
   sequence s_set_in;
      wr_ptr && in_rng;
   endsequence
   sequence s_set_out;
      wr_ptr && !in_rng;
   endsequence
   property p_tx_recessive;
      can_tx;
   endproperty
   a_tx_recessive: assert property (p_tx_recessive) else $error("tx left recessive");
   property p_unmapped_zero;
      sfr_rd && pg && !mapped |=> sfr_rdata == 8'h00;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read nonzero");
   property p_rdata_holds;
      !sfr_rd |=> $stable(sfr_rdata);
   endproperty
   a_rdata_holds: assert property (p_rdata_holds) else $error("read data moved");
   property p_ptr_top_clear;
      rd_ptr |=> !sfr_rdata[7];
   endproperty
   a_ptr_top_clear: assert property (p_ptr_top_clear) else $error("pointer bit7 set");
   property p_ptr_readback;
      wr_ptr ##1 rd_ptr |=> sfr_rdata == ($past(sfr_wdata, 2) & 8'h7F);
   endproperty
   a_ptr_readback: assert property (p_ptr_readback) else $error("pointer readback");
   property p_ptr_advance;
      s_set_in ##1 rd_low ##1 rd_ptr |=> sfr_rdata == ($past(sfr_wdata, 3) & 8'h7F) + 8'h01;
   endproperty
   a_ptr_advance: assert property (p_ptr_advance) else $error("pointer no advance");
   property p_ptr_fixed;
      s_set_out ##1 rd_low ##1 rd_ptr |=> sfr_rdata == ($past(sfr_wdata, 3) & 8'h7F);
   endproperty
   a_ptr_fixed: assert property (p_ptr_fixed) else $error("pointer moved");
   property p_rx_visible;
      $stable(can_rx) [*3] ##0 (sfr_rd && pg && sfr_addr == 8'hDB) |=>
         sfr_rdata[7] == $past(can_rx);
   endproperty
   a_rx_visible: assert property (p_rx_visible) else $error("rx level not seen");
endmodule

bind cir_can_index_bridge cir_can_index_bridge_props chk_i (.mclk(mclk), .rst(rst),
   .sfr_addr(sfr_addr), .sfr_page(sfr_page), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
   .sfr_rd(sfr_rd), .can_rx(can_rx), .sfr_rdata(sfr_rdata), .can_tx(can_tx));

`default_nettype wire

// ===== verif/tb_top.sv
// register-level bench for the indexed bridge with a transceiver model
// assumes one access per cycle driven 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   logic mclk, rst, sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val, rx_frame_stb, rx_frame_xtd;
   logic force_dom;
   logic [7:0] sfr_addr, sfr_page, sfr_wdata, n;
   logic [2:0] sfr_bit_sel;
   logic [28:0] rx_frame_id;
   wire logic [7:0] sfr_rdata;
   wire logic can_rx, can_tx, quantum_tick;
   int n_mismatch, total_checks, cycles;
   logic [23:0] rt [12] = '{24'h000001, 24'h010000, 24'h032301, 24'h080001, 24'h0AFFFF,
      24'h0BFFFF, 24'h200001, 24'h22FFFF, 24'h23FFFF, 24'h7F0000, 24'h400000, 24'h580000};
   logic [15:0] sv [6] = '{16'h0080, 16'hFFFF, 16'hFFFF, 16'h0000, 16'h848C, 16'h0400};
   logic [15:0] pt [5] = '{16'h0707, 16'h0809, 16'h1213, 16'h1313, 16'h2A2B};

   cir_can_index_bridge dut (.mclk(mclk), .rst(rst), .sfr_addr(sfr_addr), .sfr_page(sfr_page),
      .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_bit_wr(sfr_bit_wr),
      .sfr_bit_sel(sfr_bit_sel), .sfr_bit_val(sfr_bit_val), .can_rx(can_rx),
      .rx_frame_stb(rx_frame_stb), .rx_frame_id(rx_frame_id), .rx_frame_xtd(rx_frame_xtd),
      .sfr_rdata(sfr_rdata), .can_tx(can_tx), .quantum_tick(quantum_tick));
   cir_can_transceiver phy (.can_tx(can_tx), .force_dom(force_dom), .can_rx(can_rx));

   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   task automatic report_and_stop;
      if (n_mismatch == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   always @(posedge mclk)
   begin
      cycles = cycles + 1;
      if (cycles == 3000)
      begin
         n_mismatch = n_mismatch + 1;
         report_and_stop();
      end
   end

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      total_checks = total_checks + 1;
      if (g !== e)
      begin
         n_mismatch = n_mismatch + 1;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // k: 0 idle, 1 write, 2 read, 3 bit write
   task automatic acc(input int k, input logic [7:0] a, input logic [7:0] d);
      sfr_wr = k == 1;
      sfr_rd = k == 2;
      sfr_bit_wr = k == 3;
      sfr_addr = a;
      sfr_wdata = d;
      @(posedge mclk);
      #1;
   endtask

   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      acc(2, a, 8'h00);
      chk({8'h00, sfr_rdata}, {8'h00, e});
   endtask

   task automatic wwd(input logic [6:0] i, input logic [15:0] v);
      acc(1, 8'hDA, {1'b0, i});
      acc(1, 8'hD9, v[15:8]);
      acc(1, 8'hD8, v[7:0]);
   endtask

   task automatic iw(input logic [6:0] i, input logic [15:0] e);
      logic [7:0] hi;
      acc(1, 8'hDA, {1'b0, i});
      acc(2, 8'hD9, 8'h00);
      hi = sfr_rdata;
      acc(2, 8'hD8, 8'h00);
      chk({hi, sfr_rdata}, e);
   endtask

   task automatic frame(input logic [28:0] id, input logic x);
      rx_frame_id = id;
      rx_frame_xtd = x;
      rx_frame_stb = 1'b1;
      acc(0, 8'h00, 8'h00);
      rx_frame_stb = 1'b0;
      repeat (2) acc(0, 8'h00, 8'h00);
   endtask

   initial
   begin
      {sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val, rx_frame_stb, rx_frame_xtd, force_dom} = 7'h00;
      {sfr_addr, sfr_wdata, sfr_bit_sel, rx_frame_id} = 48'h0;
      sfr_page = 8'h01;
      n_mismatch = 0;
      total_checks = 0;
      cycles = 0;
      rst = 1'b1;
      repeat (10) @(posedge mclk);
      #1;
      rst = 1'b0;
      for (int i = 0; i < 12; i++) iw(rt[i][22:16], rt[i][15:0]);
      rc(8'hF8, 8'h01);
      rc(8'hC0, 8'h00);
      rc(8'hDB, 8'h80);
      acc(1, 8'hDA, 8'hFF);
      rc(8'hDA, 8'h7F);
      rc(8'h90, 8'h00);
      sfr_page = 8'h00;
      rc(8'hF8, 8'h00);
      sfr_page = 8'h01;
      wwd(7'h03, 16'h5555);
      iw(7'h03, 16'h2301);
      acc(1, 8'hF8, 8'h41);
      wwd(7'h03, 16'h2304);
      iw(7'h03, 16'h2304);
      rc(8'hD9, 8'h23);
      rc(8'hD8, 8'h04);
      acc(1, 8'hF8, 8'h01);
      wwd(7'h03, 16'h1111);
      iw(7'h03, 16'h2304);
      n = 8'h00;
      repeat (20)
      begin
         acc(0, 8'h00, 8'h00);
         n = n + quantum_tick;
      end
      chk({8'h00, n}, 16'h0004);
      wwd(7'h40, 16'h1234);
      iw(7'h40, 16'h0000);
      wwd(7'h02, 16'h1234);
      iw(7'h02, 16'h0000);
      wwd(7'h0F, 16'h00A0);
      acc(1, 8'hDA, 8'h0F);
      sfr_bit_sel = 3'h3;
      sfr_bit_val = 1'b1;
      acc(3, 8'hD8, 8'h00);
      iw(7'h0F, 16'h00A8);
      for (int i = 0; i < 5; i++)
      begin
         acc(1, 8'hDA, pt[i][15:8]);
         acc(2, 8'hD8, 8'h00);
         rc(8'hDA, pt[i][7:0]);
      end
      wwd(7'h12, 16'h0000);
      rc(8'hDA, 8'h13);
      acc(1, 8'hDA, 8'h09);
      for (int i = 0; i < 6; i++)
      begin
         acc(1, 8'hD9, sv[i][15:8]);
         acc(1, 8'hD8, sv[i][7:0]);
      end
      wwd(7'h08, 16'h0005);
      repeat (4) acc(0, 8'h00, 8'h00);
      iw(7'h58, 16'h0010);
      frame(29'h124 << 18, 1'b0);
      frame(29'h123 << 18, 1'b1);
      iw(7'h48, 16'h0000);
      rc(8'hC0, 8'h00);
      frame(29'h123 << 18, 1'b0);
      iw(7'h48, 16'h0010);
      iw(7'h50, 16'h0010);
      rc(8'hC0, 8'h10);
      wwd(7'h21, 16'h0000);
      wwd(7'h20, 16'h0005);
      repeat (4) acc(0, 8'h00, 8'h00);
      iw(7'h25, 16'h848C);
      iw(7'h26, 16'hA400);
      force_dom = 1'b1;
      repeat (4) acc(0, 8'h00, 8'h00);
      rc(8'hDB, 8'h00);
      force_dom = 1'b0;
      chk({15'h0000, can_tx}, 16'h0001);
      report_and_stop();
   end
endmodule

`default_nettype wire
